// ===== logic/acfg_regs.sv
// configuration register bank behind a mode-1 serial slave port
// assumes pins arrive asynchronously; powerdown comes from the 40 MHz domain
`timescale 1ns/100ps

module acfg_regs
	import acfg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_cs_n,
	input  wire logic       i_sclk,
	input  wire logic       i_din,
	input  wire logic       i_powerdown,
	output logic            o_dout,
	output logic            o_dout_oe,
	output logic [7:0]      o_input_gain_config,
	output logic [7:0]      o_rate_mode_config,
	output logic [7:0]      o_reference_filter_excitation_config,
	output logic [7:0]      o_current_routing_ready_config,
	output logic            o_mod_tick,
	output logic            o_mod_active,
	output logic [1:0]      o_ain_pos,
	output logic [1:0]      o_ain_neg,
	output logic            o_neg_is_supply
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		acfg_state_t     st;
		logic [7:0]      sh;
		logic [2:0]      bitcnt;
		logic [1:0]      ptr;
		logic [1:0]      remain;
		logic [7:0]      out_sh;
		logic            dout;
		logic            oe;
		logic [3:0][7:0] cfg;
		logic [25:0]     acc;
		logic            tick;
		logic [1:0]      duty;
		logic            active;
		logic [14:0]     tmo;
		logic            sclk_prev;
		logic [4:0]      pair;
	} acfg_regs_t;

	acfg_regs_t r_q;
	acfg_regs_t r_d;

	logic cs_lvl;
	logic sclk_lvl;
	logic din_lvl;
	logic rise;
	logic fall;
	logic wr_now;
	logic rd_load;
	logic [7:0] rd_val;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pins;
	logic [2:0] lvls;
	localparam logic [2:0] PIN_INIT = 3'h4;

	assign pins = {i_cs_n, i_sclk, i_din};

	for (genvar g = 0; g < 3; g++) begin : g_sync
		acfg_sync #(
			.P_INIT (PIN_INIT[g])
		) u_sync (
			.i_clk     (i_clk),
			.i_reset_n (i_reset_n),
			.i_pin     (pins[g]),
			.o_level   (lvls[g])
		);
	end

	assign cs_lvl   = lvls[2];
	assign sclk_lvl = lvls[1];
	assign din_lvl  = lvls[0];

	// supply-referenced codes return the positive input and a flag
	function automatic logic [4:0] acfg_pair(input logic [3:0] m);
		logic [4:0] p;
		p = 5'h00;
		unique case (m)
			4'h0: p = 5'h01;
			4'h1: p = 5'h02;
			4'h2: p = 5'h03;
			4'h3: p = 5'h06;
			4'h4: p = 5'h07;
			4'h5: p = 5'h0b;
			4'h6: p = 5'h04;
			4'h7: p = 5'h0e;
			4'h8, 4'h9, 4'ha, 4'hb: p = {1'b1, m[1:0], 2'h0};
			default: p = 5'h00;
		endcase
		return p;
	endfunction : acfg_pair

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic [26:0] sum;
	logic [1:0]  mode;
	logic [14:0] tmo_lim;
	logic [7:0]  byte_in;

	always_comb begin
		r_d     = r_q;
		r_d.tick = 1'b0;
		wr_now  = 1'b0;
		rd_load = 1'b0;
		rd_val  = 8'h00;
		mode    = r_q.cfg[ACFG_REG_RATE_MODE][ACFG_MODE_MSB:ACFG_MODE_LSB];
		tmo_lim = (mode == ACFG_MODE_TURBO) ? ACFG_TMO_TURBO : ACFG_TMO_NORM;
		byte_in = {r_q.sh[6:0], din_lvl};
		rise    = sclk_lvl && !r_q.sclk_prev && !cs_lvl;
		fall    = !sclk_lvl && r_q.sclk_prev && !cs_lvl;
		sum     = 27'h0;

		// fractional divider keeps the average rate exact from 40 MHz
		if (!i_powerdown) begin
			sum = {1'b0, r_q.acc} +
				((mode == ACFG_MODE_TURBO) ? ACFG_MOD_TURBO_HZ : ACFG_MOD_NORM_HZ);
			if (sum >= ACFG_CLK_HZ) begin
				r_d.acc  = 26'(sum - ACFG_CLK_HZ);
				r_d.tick = 1'b1;
			end else begin
				r_d.acc = sum[25:0];
			end
		end
		if (r_d.tick) begin
			r_d.duty = r_q.duty + 2'h1;
		end
		r_d.active = !i_powerdown &&
			(mode != ACFG_MODE_DUTY || r_d.duty == 2'h0);

		r_d.sclk_prev = sclk_lvl;
		r_d.oe        = !cs_lvl;

		if (cs_lvl) begin
			// deselect ends any frame; a select tied low gets here only in the first cycles after reset
			r_d.st     = ACFG_ST_CMD;
			r_d.bitcnt = 3'h0;
			r_d.out_sh = 8'h00;
			r_d.dout   = 1'b0;
			r_d.tmo    = 15'h0;
		end else begin
			if (rise) begin
				r_d.dout   = r_q.out_sh[7];
				r_d.out_sh = {r_q.out_sh[6:0], 1'b0};
			end
			if (rise || fall) begin
				r_d.tmo = 15'h0;
			end else if (r_q.tick && (r_q.bitcnt != 3'h0 || r_q.st != ACFG_ST_CMD)) begin
				if (r_q.tmo >= tmo_lim - 15'h1) begin
					r_d.st     = ACFG_ST_CMD;
					r_d.bitcnt = 3'h0;
					r_d.tmo    = 15'h0;
				end else begin
					r_d.tmo = r_q.tmo + 15'h1;
				end
			end
			if (fall) begin
				r_d.sh     = byte_in;
				r_d.bitcnt = r_q.bitcnt + 3'h1;
				if (r_q.bitcnt == ACFG_BIT_LAST) begin
					unique case (r_q.st)
						ACFG_ST_CMD: begin
							r_d.ptr    = byte_in[ACFG_RA_MSB:ACFG_RA_LSB];
							r_d.remain = byte_in[ACFG_CNT_MSB:0];
							if (byte_in[ACFG_OP_MSB:ACFG_OP_LSB] == ACFG_OP_READ) begin
								r_d.st  = ACFG_ST_RD;
								rd_load = 1'b1;
								rd_val  = r_q.cfg[byte_in[ACFG_RA_MSB:ACFG_RA_LSB]];
							end else if (byte_in[ACFG_OP_MSB:ACFG_OP_LSB] == ACFG_OP_WRITE) begin
								r_d.st = ACFG_ST_WR;
							end
						end
						ACFG_ST_WR: begin
							// no busy gating: conversions read the new value next cycle
							r_d.cfg[r_q.ptr] = byte_in;
							wr_now           = 1'b1;
							r_d.ptr          = r_q.ptr + 2'h1;
							if (r_q.remain == 2'h0) begin
								r_d.st = ACFG_ST_CMD;
							end else begin
								r_d.remain = r_q.remain - 2'h1;
							end
						end
						ACFG_ST_RD: begin
							if (r_q.remain == 2'h0) begin
								r_d.st = ACFG_ST_CMD;
							end else begin
								r_d.remain = r_q.remain - 2'h1;
								r_d.ptr    = r_q.ptr + 2'h1;
								rd_load    = 1'b1;
								rd_val     = r_q.cfg[r_q.ptr + 2'h1];
							end
						end
						default: r_d.st = ACFG_ST_CMD;
					endcase
				end
			end
			if (rd_load) begin
				r_d.out_sh = rd_val;
			end
		end

		r_d.pair = acfg_pair(r_d.cfg[ACFG_REG_INPUT_GAIN][ACFG_MUX_MSB:ACFG_MUX_LSB]);
	end

	// powerdown is not a term here, so contents survive it
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			r_q        <= '0;
			r_q.st     <= ACFG_ST_CMD;
			r_q.cfg    <= {4{ACFG_REG_RESET}};
			r_q.sclk_prev <= 1'b0;
			r_q.pair   <= 5'h01;
		end else begin
			r_q <= r_d;
		end
	end

	assign o_dout                               = r_q.dout;
	assign o_dout_oe                            = r_q.oe;
	assign o_input_gain_config                  = r_q.cfg[ACFG_REG_INPUT_GAIN];
	assign o_rate_mode_config                   = r_q.cfg[ACFG_REG_RATE_MODE];
	assign o_reference_filter_excitation_config = r_q.cfg[ACFG_REG_REF_FILT];
	assign o_current_routing_ready_config       = r_q.cfg[ACFG_REG_CUR_ROUTE];
	assign o_mod_tick                           = r_q.tick;
	assign o_mod_active                         = r_q.active;
	assign o_neg_is_supply                      = r_q.pair[4];
	assign o_ain_pos                            = r_q.pair[3:2];
	assign o_ain_neg                            = r_q.pair[1:0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [7:0] gap_q;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			gap_q <= 8'hff;
		end else if (r_q.tick) begin
			gap_q <= 8'h01;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	AST_OE_ON: assert property (!cs_lvl |=> o_dout_oe)
		else $error("output not driven while selected");
	AST_OE_OFF: assert property (cs_lvl ##1 cs_lvl |-> !o_dout_oe)
		else $error("output driven while deselected");
	AST_RESET_ZERO: assert property ($rose(i_reset_n) |-> r_q.cfg == '0)
		else $error("register not zero after reset");
	AST_LAUNCH: assert property (rise |=> o_dout == $past(r_q.out_sh[7]))
		else $error("output bit not launched on rise");
	AST_CAPTURE: assert property (fall |=> r_q.sh[0] == $past(din_lvl))
		else $error("input bit not captured on fall");
	AST_WRITE: assert property (wr_now |=> r_q.cfg[$past(r_q.ptr)] == $past(byte_in))
		else $error("write data not stored");
	AST_READ: assert property (rd_load |=> r_q.out_sh == r_q.cfg[r_q.ptr])
		else $error("read value not loaded");
	AST_RETAIN: assert property (!wr_now && i_powerdown |=> $stable(r_q.cfg))
		else $error("registers changed without a write");
	AST_TIMEOUT: assert property (r_q.tmo < tmo_lim)
		else $error("timeout count beyond limit");
	AST_MOD_GAP: assert property (r_q.tick && gap_q != 8'hff |-> gap_q >= 8'(ACFG_MOD_GAP_MIN))
		else $error("modulator ticks too close");
	AST_DUTY: assert property (!i_powerdown && mode != ACFG_MODE_DUTY ##1 $stable(mode)
		|-> o_mod_active)
		else $error("modulator idle outside duty mode");

endmodule : acfg_regs

// ===== logic/acfg_pkg.sv
// converter configuration bank: constants, encodings and state types
// assumes one 40 MHz system clock shared by every module that imports it
package acfg_pkg;

	// ----------------------------------------
	// clocks and modulator
	// ----------------------------------------
	localparam logic [26:0] ACFG_CLK_HZ       = 27'h2625a00; // 40000000
	localparam logic [26:0] ACFG_MOD_NORM_HZ  = 27'h003e800; // 256000
	localparam logic [26:0] ACFG_MOD_TURBO_HZ = 27'h007d000; // 512000
	localparam int          ACFG_MOD_GAP_MIN  = int'(ACFG_CLK_HZ / ACFG_MOD_TURBO_HZ);

	// interface timeout, in modulator periods
	localparam logic [14:0] ACFG_TMO_NORM  = 15'h3683; // 13955
	localparam logic [14:0] ACFG_TMO_TURBO = 15'h6d06; // 27910

	// ----------------------------------------
	// serial command byte: op[7:4] reg[3:2] count-1[1:0]
	// ----------------------------------------
	localparam logic [3:0] ACFG_OP_READ  = 4'h2;
	localparam logic [3:0] ACFG_OP_WRITE = 4'h4;
	localparam int         ACFG_OP_MSB   = 7;
	localparam int         ACFG_OP_LSB   = 4;
	localparam int         ACFG_RA_MSB   = 3;
	localparam int         ACFG_RA_LSB   = 2;
	localparam int         ACFG_CNT_MSB  = 1;
	localparam logic [2:0] ACFG_BIT_LAST = 3'h7;

	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [1:0] ACFG_REG_INPUT_GAIN = 2'h0;
	localparam logic [1:0] ACFG_REG_RATE_MODE  = 2'h1;
	localparam logic [1:0] ACFG_REG_REF_FILT   = 2'h2;
	localparam logic [1:0] ACFG_REG_CUR_ROUTE  = 2'h3;
	localparam logic [7:0] ACFG_REG_RESET      = 8'h00;
	localparam int         ACFG_MUX_MSB        = 7;
	localparam int         ACFG_MUX_LSB        = 4;
	localparam int         ACFG_MODE_MSB       = 4;
	localparam int         ACFG_MODE_LSB       = 3;

	localparam logic [1:0] ACFG_MODE_NORMAL = 2'h0;
	localparam logic [1:0] ACFG_MODE_DUTY   = 2'h1;
	localparam logic [1:0] ACFG_MODE_TURBO  = 2'h2;

	typedef enum logic [2:0] {
		ACFG_ST_CMD = 3'b001,
		ACFG_ST_WR  = 3'b010,
		ACFG_ST_RD  = 3'b100
	} acfg_state_t;

endpackage : acfg_pkg

// ===== logic/acfg_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin input and the 40 MHz system clock
`timescale 1ns/100ps

module acfg_sync
	import acfg_pkg::*;
#(
	parameter logic P_INIT = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_pin,
	output logic      o_level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} acfg_sync_t;

	acfg_sync_t r_q;
	acfg_sync_t r_d;

	// the first stage feeds only the second; level moves when stages 2 and 3 agree
	always_comb begin
		r_d    = r_q;
		r_d.s1 = i_pin;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		if (r_q.s2 == r_q.s3) begin
			r_d.lvl = r_q.s3;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			r_q <= {4{P_INIT}};
		end else begin
			r_q <= r_d;
		end
	end

	assign o_level = r_q.lvl;

endmodule : acfg_sync

// ===== test/acfg_host.sv
// serial master model for the config bank: mode-1 frames, 200 ns bit time
// assumes the bench calls xfer hierarchically, one frame at a time
// pins move on falling edges of the 40 MHz system clock only
`timescale 1ns/100ps
module acfg_host (
	input  wire logic i_clk,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_dout,
	input  wire logic i_dout_oe
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din  = 1'b0;
	end
	// ----------------------------------------
	// one framed transfer of n bytes
	// ----------------------------------------
	// sclk stands low between frames; an undriven data out reads as x
	task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
		rx = '0;
		@(negedge i_clk);
		o_cs_n = 1'b0;
		repeat (3) @(negedge i_clk);
		for (int i = 0; i < 8 * n; i++) begin
			o_sclk = 1'b1;
			o_din  = tx[39 - i];
			repeat (4) @(negedge i_clk);
			o_sclk = 1'b0;
			repeat (4) @(negedge i_clk);
			// sampled just before the next rise, long after the launch settled
			rx[39 - i] = i_dout_oe ? i_dout : 1'bx;
		end
		repeat (2) @(negedge i_clk);
		o_cs_n = 1'b1;
		o_din  = ~o_din; // released line must not look held
		repeat (4) @(negedge i_clk);
	endtask : xfer
endmodule : acfg_host

// ===== test/adc_config_regs_serial_tb.sv
// self-checking bench for the config bank: random frames, decode, modes
// assumes acfg_host as serial master; 40 MHz clock, 8-cycle reset
`timescale 1ns/100ps
module adc_config_regs_serial_tb;
	import acfg_pkg::*;
	localparam logic [15:0] POS_TAB = 16'hd940;
	localparam logic [15:0] NEG_TAB = 16'h8fb9;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        powerdown = 1'b0;
	logic        cs_n, sclk, din, dout, dout_oe, tick, active, sup;
	logic [7:0]  r0, r1, r2, r3;
	logic [1:0]  pos, neg;
	logic [39:0] rx;
	logic [7:0]  shadow [4];
	int          error_cnt = 0;
	int          n_tests = 0;
	int          all, act;
	always #12.5 clk = ~clk;
	acfg_regs u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_din(din), .i_powerdown(powerdown), .o_dout(dout), .o_dout_oe(dout_oe),
		.o_input_gain_config(r0), .o_rate_mode_config(r1),
		.o_reference_filter_excitation_config(r2), .o_current_routing_ready_config(r3),
		.o_mod_tick(tick), .o_mod_active(active), .o_ain_pos(pos), .o_ain_neg(neg),
		.o_neg_is_supply(sup));
	acfg_host u_host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout),
		.i_dout_oe(dout_oe));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	function automatic logic [4:0] exp_pair(input logic [3:0] c);
		if (c < 4'h8)
			return {1'b0, POS_TAB[2 * c +: 2], NEG_TAB[2 * c +: 2]};
		if (c < 4'hc)
			return {1'b1, c[1:0], 2'h0};
		return 5'h00;
	endfunction : exp_pair
	// keep host obligations: bypass on supply inputs, reserved bit zero
	function automatic logic [7:0] legal(input logic [1:0] ra, input logic [7:0] v);
		if (ra == 2'h0 && v[7:6] == 2'h2)
			v = {v[7:4], 3'(v[3:1] % 3), 1'b1};
		if (ra == 2'h1 && v[4:3] == 2'h3)
			v[4] = 1'b0;
		if (ra == 2'h3)
			v[0] = 1'b0;
		return v;
	endfunction : legal
	task automatic regs_ok;
		repeat (10) @(negedge clk);
		check({r0, r1}, {shadow[0], shadow[1]});
		check({r2, r3}, {shadow[2], shadow[3]});
		check({11'h0, sup, pos, neg}, {11'h0, exp_pair(shadow[0][7:4])});
		check({15'h0, dout_oe}, 16'h0);
	endtask : regs_ok
	task automatic wr(input logic [1:0] ra, input int n, input logic [31:0] d);
		logic [1:0] a;
		a = ra;
		for (int k = 0; k < n; k++) begin
			d[31 - 8 * k -: 8] = legal(a, d[31 - 8 * k -: 8]);
			shadow[a] = d[31 - 8 * k -: 8];
			a = a + 2'h1;
		end
		u_host.xfer(n + 1, {ACFG_OP_WRITE, ra, 2'(n - 1), d}, rx);
		regs_ok();
	endtask : wr
	task automatic rd(input logic [1:0] ra, input int n);
		u_host.xfer(n + 1, {ACFG_OP_READ, ra, 2'(n - 1), 32'h0}, rx);
		for (int k = 0; k < n; k++)
			check({8'h0, rx[31 - 8 * k -: 8]}, {8'h0, shadow[2'(ra + k)]});
	endtask : rd
	task automatic ticks(input int e_all, input int e_act);
		all = 0;
		act = 0;
		repeat (2500) @(negedge clk) begin
			all += int'(tick === 1'b1);
			act += int'(tick === 1'b1 && active === 1'b1);
		end
		check(16'(all >= e_all - 1 && all <= e_all + 1), 16'h1);
		check(16'(act >= e_act - 1 && act <= e_act + 1), 16'h1);
	endtask : ticks
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hd79b75a2));
		shadow = '{default: 8'h00};
		repeat (8) @(posedge clk);
		@(negedge clk) reset_n = 1'b1;
		regs_ok();
		rd(2'h0, 4);
		repeat (6) begin
			wr(2'($urandom), $urandom_range(1, 4), $urandom);
			rd(2'($urandom), 4);
		end
		wr(2'h3, 4, $urandom);
		rd(2'h3, 2);
		// unknown opcodes are ignored and must leave every register alone
		u_host.xfer(2, {8'h0f, 8'hff, 24'h0}, rx);
		regs_ok();
		for (int c = 0; c < 16; c++)
			wr(2'h0, 1, {4'(c), 28'h0});
		wr(2'h1, 1, 32'h0);
		ticks(16, 16);
		wr(2'h1, 1, 32'h0800_0000);
		ticks(16, 4);
		wr(2'h1, 1, 32'h1000_0000);
		ticks(32, 32);
		@(negedge clk) powerdown = 1'b1;
		ticks(0, 0);
		regs_ok();
		@(negedge clk) powerdown = 1'b0;
		regs_ok();
		rd(2'h0, 4);
		wr(2'h2, 2, $urandom);
		@(negedge clk) reset_n = 1'b0;
		repeat (8) @(negedge clk);
		reset_n = 1'b1;
		shadow = '{default: 8'h00};
		regs_ok();
		rd(2'h1, 4);
		stop_test();
	end
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule : adc_config_regs_serial_tb
